// file: hdl/railroad_preempt_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
module railroad_preempt_supervisor #(
  parameter int unsigned TICK_DIV = rr_preempt_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [5:0] planDemand,
  input wire logic railDemand,
  input wire logic railSecondary,
  input wire logic superviseOk,
  input wire logic superviseSelfOk,
  input wire logic testSwitch,
  input wire logic seriesLoopOk,
  input wire logic [15:0] wiredId,
  input wire logic manualReset,
  input wire rr_preempt_pkg::cfg_bus_t cfgBus,
  output logic [15:0] cfgRdata,
  output logic cfgWriteRefused,
  output logic [2:0] activePlan,
  output logic planActive,
  output rr_preempt_pkg::seq_t seqState,
  output logic trackGreen,
  output logic pedFlashDontWalk,
  output logic relayDrive,
  output logic lineLamp,
  output logic flashOutInverted,
  output rr_preempt_pkg::alarm_t alarms,
  output logic [15:0] computedId
);
  import rr_preempt_pkg::*;

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--)
    begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crcStep

  // Two-stage input synchronisers
  logic [28:0] syncA;
  logic [28:0] syncB;
  wire [28:0] rawIn = {planDemand, railDemand, railSecondary, superviseOk,
    superviseSelfOk, testSwitch, seriesLoopOk, manualReset, wiredId};
  always_ff @(posedge mclk)
  begin
    syncA <= rawIn;
    syncB <= syncA;
  end
  wire [5:0] sPlan = syncB[28:23];
  wire sDemand = syncB[22];
  wire sSecond = syncB[21];
  wire sSupOk = syncB[20];
  wire sSelfOk = syncB[19];
  wire sTest = syncB[18];
  wire sLoop = syncB[17];
  wire sManual = syncB[16];
  wire [15:0] sWired = syncB[15:0];

  // One-second timebase
  logic [27:0] tickCnt;
  logic tick;
  wire tickWrap = (tickCnt == 28'(TICK_DIV - 1));
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tickCnt <= 28'h000_0000;
      tick <= 1'b0;
    end
    else
    begin
      tick <= tickWrap;
      tickCnt <= tickWrap ? 28'h000_0000 : tickCnt + 28'h000_0001;
    end
  end

  // Protected data store and identifier
  logic [15:0] cfgMem [0:15];
  logic [15:0] crcAcc;
  logic [3:0] crcIdx;
  logic crcValid;
  logic dataChanged;
  wire walkEnd = (crcIdx == 4'hF);
  wire inFlash = (seqState == ST_FLASH);
  wire cfgWrOk = cfgBus.wr && inFlash;
  always_ff @(posedge mclk)
  begin
    if (cfgWrOk)
    begin
      cfgMem[cfgBus.addr] <= cfgBus.data;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cfgRdata <= 16'h0000;
      cfgWriteRefused <= 1'b0;
    end
    else
    begin
      cfgRdata <= cfgBus.rd ? cfgMem[cfgBus.addr] : 16'h0000;
      cfgWriteRefused <= cfgBus.wr && !inFlash;
    end
  end
  // Continuous identifier walk over protected words
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      crcAcc <= CRC_INIT;
      crcIdx <= 4'h0;
      computedId <= 16'h0000;
      crcValid <= 1'b0;
    end
    else if (cfgWrOk)
    begin
      crcAcc <= CRC_INIT;
      crcIdx <= 4'h0;
      crcValid <= 1'b0;
    end
    else
    begin
      crcAcc <= walkEnd ? CRC_INIT : crcStep(crcAcc, cfgMem[crcIdx]);
      crcIdx <= crcIdx + 4'h1;
      if (walkEnd)
      begin
        computedId <= crcStep(crcAcc, cfgMem[crcIdx]);
        crcValid <= 1'b1;
      end
    end
  end
  wire idMismatch = crcValid && tick && (computedId != sWired);
  wire idMatch = crcValid && (computedId == sWired);

  // Input verification timer
  logic [3:0] equalSecs;
  wire inputsEqual = (sDemand == sSecond);
  always_ff @(posedge mclk)
  begin
    if (rst || !inputsEqual)
    begin
      equalSecs <= TIMER_ZERO;
    end
    else if (tick && equalSecs != 4'hF)
    begin
      equalSecs <= equalSecs + 4'h1;
    end
  end
  wire inputFailNow = inputsEqual && (equalSecs > 4'(INPUT_FAIL_SEC));

  // Priority among plans: plan 0 highest
  wire superFailNow = !sSupOk || !sSelfOk;
  wire [5:0] demands = {sPlan[5:2], sPlan[1] | sDemand | sTest, sPlan[0] | superFailNow};
  logic [2:0] nextPlan;
  always_comb
  begin
    nextPlan = 3'h0;
    for (int i = NUM_PLANS - 1; i >= 0; i--)
    begin
      if (demands[i])
      begin
        nextPlan = 3'(i);
      end
    end
  end
  wire anyDemand = |demands;
  wire railCall = demands[0] || demands[1] || inputFailNow;

  // Latched faults
  logic flashAfterTrack;
  logic prevRail;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      alarms <= '0;
      flashAfterTrack <= 1'b0;
      dataChanged <= 1'b0;
      prevRail <= 1'b0;
    end
    else
    begin
      prevRail <= railCall;
      if (sManual)
      begin
        alarms <= '0;
        flashAfterTrack <= 1'b0;
        dataChanged <= 1'b0;
      end
      if (superFailNow)
      begin
        alarms.superviseFail <= 1'b1;
        flashAfterTrack <= 1'b1;
      end
      if (inputFailNow)
      begin
        alarms.inputFail <= 1'b1;
        flashAfterTrack <= 1'b1;
      end
      if (idMismatch)
      begin
        alarms.crcFail <= 1'b1;
      end
      if (!sLoop)
      begin
        alarms.loopFail <= 1'b1;
      end
      if (cfgWrOk)
      begin
        dataChanged <= 1'b1;
      end
    end
  end
  wire newDemand = railCall && !prevRail;
  wire hardFlash = alarms.crcFail || alarms.loopFail || !sLoop || idMismatch;
  wire holdFlash = hardFlash || dataChanged || !crcValid;

  // Preemption sequence
  logic [3:0] secs;
  seq_t nextState;
  logic [3:0] nextSecs;
  logic startGreen;
  always_comb
  begin
    nextState = seqState;
    nextSecs = tick ? secs - 4'h1 : secs;
    startGreen = 1'b0;
    case (seqState)
      ST_NORMAL:
      begin
        if (holdFlash)
        begin
          nextState = ST_FLASH;
        end
        else if (railCall)
        begin
          nextState = ST_YELLOW;
          nextSecs = 4'(CLEAR_YELLOW_SEC);
        end
      end
      ST_YELLOW:
      begin
        if (secs == TIMER_ZERO)
        begin
          nextState = ST_RED;
          nextSecs = 4'(CLEAR_RED_SEC);
        end
      end
      ST_RED:
      begin
        if (secs == TIMER_ZERO)
        begin
          startGreen = 1'b1;
        end
      end
      ST_TRACK_GREEN:
      begin
        if (newDemand)
        begin
          startGreen = 1'b1;
        end
        else if (secs == TIMER_ZERO)
        begin
          nextState = ST_TRACK_RED;
          nextSecs = 4'(TRACK_RED_SEC);
        end
      end
      ST_TRACK_RED:
      begin
        if (newDemand)
        begin
          startGreen = 1'b1;
        end
        else if (secs == TIMER_ZERO)
        begin
          nextState = flashAfterTrack ? ST_FLASH : ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        if (newDemand)
        begin
          startGreen = 1'b1;
        end
        else if (!railCall)
        begin
          nextState = ST_NORMAL;
        end
      end
      ST_FLASH:
      begin
        if (sManual && !hardFlash && idMatch && !railCall)
        begin
          nextState = ST_NORMAL;
        end
      end
      default:
      begin
        nextState = ST_FLASH;
      end
    endcase
    if (startGreen)
    begin
      nextState = ST_TRACK_GREEN;
      nextSecs = 4'(TRACK_GREEN_SEC);
    end
    if (hardFlash)
    begin
      nextState = ST_FLASH;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      seqState <= ST_FLASH;
      secs <= TIMER_ZERO;
      activePlan <= 3'h0;
      planActive <= 1'b0;
    end
    else
    begin
      seqState <= nextState;
      secs <= (nextState != seqState || startGreen) ? nextSecs :
        (tick && secs != TIMER_ZERO ? secs - 4'h1 : secs);
      activePlan <= nextPlan;
      planActive <= anyDemand;
    end
  end

  // Outputs
  assign trackGreen = (seqState == ST_TRACK_GREEN);
  assign pedFlashDontWalk = (seqState == ST_YELLOW);
  assign relayDrive = !railCall && !inFlash;
  assign lineLamp = sTest || sDemand;
  assign flashOutInverted = !inFlash;
endmodule : railroad_preempt_supervisor
`default_nettype wire

// file: hdl/rr_preempt_pkg.sv
// Behaviour
// - Six preemption plans, fixed priority order
// - Every new demand restarts track clearance green
// - Vehicle clearances incl. red revert complete first
// - Ped flashing don't-walk only during yellow
// - Test switch injects call, shows line powered
// - Missing critical component forces flash
// - Interface relay energized when not preempted; code also de-energizes it in flash
// - Series loop must close; open latches flash
// - Interconnect failure: one clearance, then latched flash
// - Interconnect failure raises supervisory alarm
// - Supervision self-fault also forces flash
// - Compute 16-bit identifier over protected data
// - Expected identifier wired as 16 input lines
// - Compare identifier at least once per second
// - Mismatch: all-red flash, alarm, manual restart
// - Protected writes only while flashing red
// - After data change, restart and verify first
// - Flash output polarity inverted
// - Secondary input opposite to primary demand
// - Equal inputs over one second: input failure
// - Input failure: clearance, flash, alarm, latched
package rr_preempt_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned TICK_PERIOD_MS = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_PERIOD_MS;
  localparam int unsigned INPUT_FAIL_SEC = 1;
  localparam int unsigned CLEAR_YELLOW_SEC = 4;
  localparam int unsigned CLEAR_RED_SEC = 2;
  localparam int unsigned TRACK_GREEN_SEC = 15;
  localparam int unsigned TRACK_RED_SEC = 2;
  localparam int unsigned NUM_PLANS = 6;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [4:0] DATA_WORDS = 5'h10;
  localparam logic [3:0] TIMER_ZERO = 4'h0;

  typedef enum logic [2:0] {
    ST_NORMAL = 3'b000,
    ST_YELLOW = 3'b001,
    ST_RED = 3'b010,
    ST_TRACK_GREEN = 3'b011,
    ST_TRACK_RED = 3'b100,
    ST_HOLD = 3'b101,
    ST_FLASH = 3'b110
  } seq_t;

  typedef struct packed {
    logic superviseFail;
    logic inputFail;
    logic crcFail;
    logic loopFail;
  } alarm_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] data;
    logic wr;
    logic rd;
  } cfg_bus_t;
endpackage : rr_preempt_pkg

// file: verif/rr_preempt_sva.sv
`timescale 1ns/1ns
`default_nettype none
module rr_preempt_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic seriesLoopOk,
  input wire logic superviseOk,
  input wire logic testSwitch,
  input wire rr_preempt_pkg::cfg_bus_t cfgBus,
  input wire logic cfgWriteRefused,
  input wire rr_preempt_pkg::seq_t seqState,
  input wire logic trackGreen,
  input wire logic pedFlashDontWalk,
  input wire logic relayDrive,
  input wire logic lineLamp,
  input wire logic flashOutInverted,
  input wire rr_preempt_pkg::alarm_t alarms
);
  import rr_preempt_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence loopOpen;
    !seriesLoopOk [*4];
  endsequence
  sequence cableLost;
    !superviseOk [*4];
  endsequence
  a_green_decode: assert property (trackGreen == (seqState == ST_TRACK_GREEN))
    else $error("green mismatch");
  a_ped_yellow: assert property (pedFlashDontWalk == (seqState == ST_YELLOW))
    else $error("ped mismatch");
  a_relay_flash: assert property (seqState == ST_FLASH |-> !relayDrive)
    else $error("relay on in flash");
  a_flash_invert: assert property (flashOutInverted == (seqState != ST_FLASH))
    else $error("flash polarity");
  a_write_refused: assert property
    (cfgBus.wr && seqState != ST_FLASH |=> cfgWriteRefused) else $error("no refusal");
  a_loop_flash: assert property
    (loopOpen |-> ##[0:3] (alarms.loopFail && seqState == ST_FLASH)) else $error("loop");
  a_cable_alarm: assert property (cableLost |-> ##[0:3] alarms.superviseFail)
    else $error("cable alarm missed");
  a_test_lamp: assert property (testSwitch [*5] |-> lineLamp)
    else $error("lamp off");
  a_green_entry: assert property
    ((seqState == ST_TRACK_GREEN && $past(seqState) != ST_TRACK_GREEN) |->
      ($past(seqState) inside {ST_RED, ST_TRACK_RED, ST_HOLD})) else $error("green entry");
  a_write_taken: assert property
    (cfgBus.wr && seqState == ST_FLASH |=> !cfgWriteRefused) else $error("flash write refused");
endmodule : rr_preempt_sva
bind railroad_preempt_supervisor rr_preempt_sva chk (.*);
`default_nettype wire

// file: verif/rail_equipment_model.sv
`timescale 1ns/1ns
`default_nettype none
module rail_equipment_model (
  input wire logic mclk,
  input wire logic flashersOn,
  input wire logic badSecondary,
  input wire logic cableCut,
  output logic railDemand,
  output logic railSecondary,
  output logic superviseOk
);
  always_ff @(posedge mclk)
  begin
    railDemand <= flashersOn;
    railSecondary <= ~(flashersOn | badSecondary);
    superviseOk <= ~cableCut;
  end
endmodule : rail_equipment_model
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import rr_preempt_pkg::*;
  localparam int TD = 20;
  logic mclk, rst, railDemand, railSecondary, superviseOk, superviseSelfOk, testSwitch;
  logic seriesLoopOk, manualReset, flashersOn, badSecondary, cableCut, cfgWriteRefused;
  logic planActive, trackGreen, pedFlashDontWalk, relayDrive, lineLamp, flashOutInverted;
  logic [5:0] planDemand;
  logic [15:0] wiredId, cfgRdata, computedId, goodId;
  logic [2:0] activePlan;
  logic [3:0] expAlarm [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h8};
  cfg_bus_t cfgBus;
  seq_t seqState;
  alarm_t alarms;
  int badCount = 0, numChecks = 0, cnt;
  railroad_preempt_supervisor #(.TICK_DIV(TD)) dut (.*);
  rail_equipment_model farSide (.*);
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      badCount++;
      $display("ERROR %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic giveVerdict();
    $display("checks %0d bad %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : giveVerdict
  task automatic wait_state(input seq_t s);
    cnt = 0;
    while (seqState !== s && cnt < 3000)
    begin
      @(negedge mclk);
      cnt++;
    end
    if (cnt == 3000)
    begin
      check(1'b0, 1'b1);
      giveVerdict();
    end
  endtask : wait_state
  function automatic logic [15:0] word_of(input int i);
    return 16'h9a3c ^ (16'h0111 * i[15:0]);
  endfunction : word_of
  function automatic logic [15:0] crc_all();
    logic [15:0] c, w;
    c = CRC_INIT;
    for (int i = 0; i < 16; i++)
    begin
      w = word_of(i);
      for (int b = 15; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ w[b]) ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction : crc_all
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    cfgBus <= '{addr: a, data: d, wr: w, rd: ~w};
    @(posedge mclk);
    cfgBus <= '0;
    @(negedge mclk);
  endtask : bus
  task automatic set_faults(input int k);
    @(posedge mclk);
    seriesLoopOk <= (k != 0);
    wiredId <= (k == 1) ? ~goodId : goodId;
    badSecondary <= (k == 2);
    cableCut <= (k == 3);
    superviseSelfOk <= (k != 4);
  endtask : set_faults
  task automatic restart();
    repeat (3 * TD) @(posedge mclk);
    manualReset <= 1'b1;
    repeat (4) @(posedge mclk);
    manualReset <= 1'b0;
    wait_state(ST_NORMAL);
  endtask : restart
  task automatic t_start();
    check(seqState, ST_FLASH);
    check({relayDrive, flashOutInverted}, 2'b00);
    for (int i = 0; i < 16; i++)
    begin
      bus(1'b1, i[3:0], word_of(i));
      check(cfgWriteRefused, 1'b0);
    end
    bus(1'b0, 4'h5, 16'h0000);
    check(cfgRdata, word_of(5));
    @(negedge mclk);
    check(cfgRdata, 16'h0000);
    goodId = crc_all();
    set_faults(9);
    restart();
    check(computedId, goodId);
    check({relayDrive, flashOutInverted}, 2'b11);
    $display("start done");
  endtask : t_start
  task automatic t_plans();
    bus(1'b1, 4'h0, 16'h0000);
    check(cfgWriteRefused, 1'b1);
    @(posedge mclk);
    planDemand <= 6'h28;
    repeat (5) @(negedge mclk);
    check({planActive, activePlan}, 4'hb);
    @(posedge mclk);
    planDemand <= 6'h2c;
    repeat (5) @(negedge mclk);
    check({planActive, activePlan}, 4'ha);
    @(posedge mclk);
    planDemand <= 6'h22;
    wait_state(ST_YELLOW);
    check({planActive, activePlan}, 4'h9);
    @(posedge mclk);
    planDemand <= 6'h00;
    wait_state(ST_NORMAL);
    $display("plans done");
  endtask : t_plans
  task automatic t_rail();
    @(posedge mclk);
    flashersOn <= 1'b1;
    wait_state(ST_YELLOW);
    check({pedFlashDontWalk, relayDrive}, 2'b10);
    wait_state(ST_RED);
    wait_state(ST_TRACK_GREEN);
    repeat (10 * TD) @(posedge mclk);
    flashersOn <= 1'b0;
    repeat (4) @(posedge mclk);
    flashersOn <= 1'b1;
    cnt = 0;
    while (trackGreen === 1'b1 && cnt < 20 * TD)
    begin
      @(negedge mclk);
      cnt++;
    end
    check(cnt > 12 * TD && cnt < 20 * TD, 1'b1);
    if (cnt == 20 * TD)
      giveVerdict();
    @(posedge mclk);
    flashersOn <= 1'b0;
    wait_state(ST_NORMAL);
    $display("rail done");
  endtask : t_rail
  task automatic t_sw();
    @(posedge mclk);
    testSwitch <= 1'b1;
    wait_state(ST_YELLOW);
    check(lineLamp, 1'b1);
    @(posedge mclk);
    testSwitch <= 1'b0;
    wait_state(ST_NORMAL);
    check(lineLamp, 1'b0);
    $display("switch done");
  endtask : t_sw
  task automatic t_fault(input int k);
    set_faults(k);
    if (k >= 2)
      wait_state(ST_TRACK_GREEN);
    wait_state(ST_FLASH);
    if (k == 1)
      check(cnt <= 2 * TD + 8, 1'b1);
    check(alarms & expAlarm[k], expAlarm[k]);
    set_faults(9);
    repeat (TD) @(negedge mclk);
    check(seqState, ST_FLASH);
    restart();
    check(alarms, 4'h0);
    check(computedId, goodId);
    $display("fault done");
  endtask : t_fault
  initial
  begin
    rst = 1'b1;
    planDemand = 6'h00;
    testSwitch = 1'b0;
    manualReset = 1'b0;
    cfgBus = '0;
    flashersOn = 1'b0;
    wiredId = 16'h0000;
    goodId = 16'h0000;
    seriesLoopOk = 1'b1;
    badSecondary = 1'b0;
    cableCut = 1'b0;
    superviseSelfOk = 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    t_start();
    t_plans();
    t_rail();
    t_sw();
    for (int k = 0; k < 5; k++)
      t_fault(k);
    giveVerdict();
  end
endmodule : tb
`default_nettype wire
